// ===== hdl/pbw_ctrl.sv
// pushbutton wake, long press and watchdog reset controller
`timescale 1ns/1ps
`default_nettype none
module pbw_ctrl
  import pbw_pkg::*;
#(
  parameter longint WDOG_CYCLES = WDOG_CYC,
  parameter int CYCLE_OFF_CYCLES = CYCLE_OFF_CYC,
  parameter int PULSE_CYCLES = INT_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pins
  input wire logic button_in_n,
  input wire logic input_supply_valid,
  output logic int_oe,
  output logic int_out,
  // power control
  input wire logic start_ship_mode,
  input wire logic regulator_enable,
  input wire logic startup_ok,
  output logic always_on_supply,
  output logic system_rail,
  output logic regulator_out,
  output logic ship_mode,
  // timer settings, in core clock cycles, and long press options
  input wire logic [DUR_W-1:0] first_press_timer,
  input wire logic [DUR_W-1:0] second_press_timer,
  input wire logic [DUR_W-1:0] long_press_timer,
  input wire logic [DUR_W-1:0] warning_interval_setting,
  input wire logic [1:0] long_press_action,
  input wire logic reset_requires_input_supply,
  // host controls
  input wire logic soft_power_cycle_request,
  input wire logic adapter_watchdog_enable,
  input wire logic bus_activity,
  input wire logic flags_read,
  input wire logic other_int_event,
  input wire logic mask_first,
  input wire logic mask_second,
  input wire logic mask_warning,
  input wire logic mask_other,
  // flags
  output logic first_press_flag,
  output logic second_press_flag,
  output logic long_press_warning_flag
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic btn_s1, btn_s2, vin_s1, vin_s2;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      btn_s1 <= 1'b1;
      btn_s2 <= 1'b1;
      vin_s1 <= 1'b0;
      vin_s2 <= 1'b0;
    end else begin
      btn_s1 <= button_in_n;
      btn_s2 <= btn_s1;
      vin_s1 <= input_supply_valid;
      vin_s2 <= vin_s1;
    end
  end

  logic pressed;
  assign pressed = ~btn_s2;

  // ----------------------------------------
  // press timers and state
  // ----------------------------------------
  pbw_state_t state, next_state;
  logic [TICK_W-1:0] press_cnt, next_press_cnt;
  logic [DUR_W-1:0] dur1, dur2, durl, durw;
  logic [DUR_W-1:0] next_dur1, next_dur2, next_durl, next_durw;
  logic armed, next_armed;
  logic vin_whole, next_vin_whole;
  logic t1_done, t2_done, tl_done, tw_done;
  logic next_t1_done, next_t2_done, next_tl_done, next_tw_done;
  logic [TICK_W-1:0] off_cnt, next_off_cnt;
  logic [TICK_W-1:0] wd_cnt, next_wd_cnt;
  logic wd_run, next_wd_run, vin_prev;
  logic f1, f2, fw, next_f1, next_f2, next_fw;
  logic ev1, ev2, evw, fire;
  logic started, next_started;

  function automatic logic hit(input logic [TICK_W-1:0] cnt, input logic [DUR_W-1:0] dur);
    hit = (cnt == TICK_W'(dur));
  endfunction

  always_comb begin
    next_state = state;
    next_press_cnt = press_cnt;
    next_dur1 = dur1;
    next_dur2 = dur2;
    next_durl = durl;
    next_durw = durw;
    next_armed = armed;
    next_vin_whole = vin_whole;
    next_t1_done = t1_done;
    next_t2_done = t2_done;
    next_tl_done = tl_done;
    next_tw_done = tw_done;
    next_off_cnt = off_cnt;
    ev1 = 1'b0;
    ev2 = 1'b0;
    evw = 1'b0;
    if (!pressed) begin
      next_press_cnt = '0;
      next_armed = 1'b1;
      next_vin_whole = 1'b1;
      next_t1_done = 1'b0;
      next_t2_done = 1'b0;
      next_tl_done = 1'b0;
      next_tw_done = 1'b0;
      next_dur1 = first_press_timer;
      next_dur2 = second_press_timer;
      next_durl = long_press_timer;
      next_durw = warning_interval_setting;
    end else begin
      next_press_cnt = press_cnt + TICK_W'(1);
      if (!vin_s2) begin
        next_vin_whole = 1'b0;
      end
      if (!t1_done && hit(press_cnt, dur1)) begin
        next_t1_done = 1'b1;
        ev1 = armed && state == PBW_RUN;
      end
      if (!t2_done && hit(press_cnt, dur1 + dur2)) begin
        next_t2_done = 1'b1;
        ev2 = armed && state == PBW_RUN;
      end
      if (!tw_done && durw <= durl && hit(press_cnt, durl - durw)) begin
        next_tw_done = 1'b1;
        evw = armed && state == PBW_RUN;
      end
    end
    unique case (state)
      PBW_RUN: begin
        if (pressed && !tl_done && hit(press_cnt, durl)) begin
          next_tl_done = 1'b1;
          if (armed) begin
            if ((long_press_action & LPA_SHIP_BIT) != '0) begin
              next_state = PBW_SHIP;
            end else if (long_press_action == LPA_POWER_CYCLE && (vin_whole || !reset_requires_input_supply)) begin
              next_state = PBW_CYCLE_OFF;
              next_off_cnt = '0;
            end
          end
        end
        if (soft_power_cycle_request || (wd_run && wd_cnt == TICK_W'(WDOG_CYCLES))) begin
          next_state = PBW_CYCLE_OFF;
          next_off_cnt = '0;
        end
        if (start_ship_mode) begin
          next_state = PBW_SHIP;
        end
      end
      PBW_SHIP: begin
        if (vin_s2) begin
          next_state = PBW_RUN;
        end else if (pressed) begin
          next_state = PBW_WAKING;
          next_press_cnt = '0;
          next_dur2 = second_press_timer;
        end
      end
      PBW_WAKING: begin
        if (vin_s2) begin
          next_state = PBW_RUN;
          next_armed = ~pressed;
        end else if (!pressed) begin
          next_state = PBW_SHIP;
        end else if (hit(press_cnt, dur2)) begin
          next_state = PBW_RUN;
          next_armed = 1'b0;
          next_t1_done = 1'b1;
          next_t2_done = 1'b1;
          next_tw_done = 1'b1;
          next_tl_done = 1'b1;
        end
      end
      PBW_CYCLE_OFF: begin
        next_off_cnt = off_cnt + TICK_W'(1);
        if (off_cnt == TICK_W'(CYCLE_OFF_CYCLES)) begin
          next_state = PBW_CYCLE_ON;
        end
      end
      PBW_CYCLE_ON: begin
        next_state = PBW_RUN;
        next_armed = ~pressed;
      end
      default: begin
        next_state = PBW_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // watchdog, flags and start-up
  // ----------------------------------------
  always_comb begin
    next_wd_run = wd_run;
    next_wd_cnt = wd_cnt;
    if (!adapter_watchdog_enable || !vin_s2 || bus_activity) begin
      next_wd_run = 1'b0;
      next_wd_cnt = '0;
    end else if (vin_s2 && !vin_prev) begin
      next_wd_run = 1'b1;
      next_wd_cnt = '0;
    end else if (wd_run) begin
      next_wd_cnt = wd_cnt + TICK_W'(1);
      if (wd_cnt == TICK_W'(WDOG_CYCLES)) begin
        next_wd_run = 1'b0;
      end
    end
    // set wins over a host read clear
    next_f1 = ev1 | (f1 & ~flags_read);
    next_f2 = ev2 | (f2 & ~flags_read);
    next_fw = evw | (fw & ~flags_read);
    next_started = started | startup_ok;
  end

  // pulse on a fresh flag set or an other event, unmasked, after start-up
  assign fire = started && ((ev1 && !f1 && !mask_first) || (ev2 && !f2 && !mask_second)
                || (evw && !fw && !mask_warning) || (other_int_event && !mask_other));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= PBW_RUN;
      press_cnt <= '0;
      dur1 <= '0;
      dur2 <= '0;
      durl <= '0;
      durw <= '0;
      armed <= 1'b1;
      vin_whole <= 1'b1;
      t1_done <= 1'b0;
      t2_done <= 1'b0;
      tl_done <= 1'b0;
      tw_done <= 1'b0;
      off_cnt <= '0;
      wd_cnt <= '0;
      wd_run <= 1'b0;
      vin_prev <= 1'b0;
      f1 <= 1'b0;
      f2 <= 1'b0;
      fw <= 1'b0;
      started <= 1'b0;
    end else begin
      state <= next_state;
      press_cnt <= next_press_cnt;
      dur1 <= next_dur1;
      dur2 <= next_dur2;
      durl <= next_durl;
      durw <= next_durw;
      armed <= next_armed;
      vin_whole <= next_vin_whole;
      t1_done <= next_t1_done;
      t2_done <= next_t2_done;
      tl_done <= next_tl_done;
      tw_done <= next_tw_done;
      off_cnt <= next_off_cnt;
      wd_cnt <= next_wd_cnt;
      wd_run <= next_wd_run;
      vin_prev <= vin_s2;
      f1 <= next_f1;
      f2 <= next_f2;
      fw <= next_fw;
      started <= next_started;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign first_press_flag = f1;
  assign second_press_flag = f2;
  assign long_press_warning_flag = fw;
  assign ship_mode = (state == PBW_SHIP) || (state == PBW_WAKING);
  assign always_on_supply = (state != PBW_SHIP);
  assign system_rail = (state == PBW_RUN) || (state == PBW_CYCLE_ON);
  assign regulator_out = system_rail && regulator_enable;

  pbw_int_pulse #(
    .PULSE_CYC(PULSE_CYCLES)
  ) u_int (
    .core_clk(core_clk),
    .reset(reset),
    .fire(fire),
    .int_oe(int_oe),
    .int_out(int_out)
  );

endmodule
`default_nettype wire

// ===== shared/pbw_pkg.sv
// shared constants and types for the pushbutton wake and reset controller
package pbw_pkg;

  // timing in native units
  localparam int CLK_MHZ = 250;
  localparam int INT_PULSE_US = 128;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int WDOG_S = 14;
  localparam longint WDOG_CYC = longint'(WDOG_S) * 1000000 * CLK_MHZ;

  // press timer field widths and unit (timer ticks counted in core clocks)
  localparam int DUR_W = 32;
  localparam int TICK_W = 40;

  // long press action encodings
  localparam logic [1:0] LPA_POWER_CYCLE = 2'h0;
  localparam logic [1:0] LPA_NOTHING = 2'h1;
  localparam logic [1:0] LPA_SHIP_BIT = 2'h2;

  // power sequencer states
  typedef enum logic [2:0] {
    PBW_RUN = 3'b000,
    PBW_SHIP = 3'b001,
    PBW_WAKING = 3'b010,
    PBW_CYCLE_OFF = 3'b011,
    PBW_CYCLE_ON = 3'b100
  } pbw_state_t;

  // power cycle off time
  localparam int CYCLE_OFF_US = 1;
  localparam int CYCLE_OFF_CYC = CYCLE_OFF_US * CLK_MHZ;

endpackage

// ===== hdl/pbw_int_pulse.sv
// open-drain interrupt pulse generator
`timescale 1ns/1ps
`default_nettype none
module pbw_int_pulse
  import pbw_pkg::*;
#(
  parameter int PULSE_CYC = INT_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // request
  input wire logic fire,
  // pin
  output logic int_oe,
  output logic int_out
);

  localparam int CNT_W = $clog2(PULSE_CYC + 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // ----------------------------------------
  // pulse length counter
  // ----------------------------------------
  always_comb begin
    next_count = count;
    if (fire) begin
      next_count = CNT_W'(PULSE_CYC);
    end else if (count != '0) begin
      next_count = count - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign int_oe = (count != '0);
  assign int_out = 1'b0;

endmodule
`default_nettype wire

// ===== test/pbw_ctrl_sva.sv
// assertion checker for the pushbutton wake and reset controller
`timescale 1ns/1ps
`default_nettype none
module pbw_ctrl_sva
  import pbw_pkg::*;
#(
  parameter longint WDOG_CYCLES = WDOG_CYC,
  parameter int CYCLE_OFF_CYCLES = CYCLE_OFF_CYC,
  parameter int PULSE_CYCLES = INT_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // inputs
  input wire logic startup_ok,
  input wire logic flags_read,
  input wire logic mask_first,
  input wire logic mask_second,
  input wire logic mask_warning,
  // outputs
  input wire logic int_oe,
  input wire logic first_press_flag,
  input wire logic second_press_flag,
  input wire logic long_press_warning_flag,
  input wire logic ship_mode,
  input wire logic system_rail,
  input wire logic regulator_out,
  input wire logic always_on_supply
);
  logic [31:0] pulse_len, next_pulse_len;
  logic started, next_started;
  // ----------
  // helpers
  // ----------
  always_comb begin
    next_pulse_len = int_oe ? pulse_len + 32'h0000_0001 : 32'h0000_0000;
    next_started = started | startup_ok;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pulse_len <= 32'h0000_0000;
      started <= 1'b0;
    end else begin
      pulse_len <= next_pulse_len;
      started <= next_started;
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_pulse_width: assert property ($fell(int_oe) |-> pulse_len == PULSE_CYCLES)
    else $error("interrupt pulse length wrong");
  a_no_early_int: assert property (!started |-> !int_oe)
    else $error("interrupt before start-up");
  a_first_pulse: assert property ($rose(first_press_flag) && !$past(mask_first) && $past(started) |-> int_oe)
    else $error("first flag without pulse");
  a_second_pulse: assert property ($rose(second_press_flag) && !$past(mask_second) && $past(started) |-> int_oe)
    else $error("second flag without pulse");
  a_warn_pulse: assert property ($rose(long_press_warning_flag) && !$past(mask_warning) && $past(started) |-> int_oe)
    else $error("warning flag without pulse");
  a_flag_hold: assert property (first_press_flag && !flags_read |=> first_press_flag)
    else $error("flag lost before read");
  a_ship_dark: assert property (ship_mode |-> !system_rail && !regulator_out)
    else $error("rail powered in ship mode");
  a_cycle_aon: assert property (!ship_mode && !system_rail |-> always_on_supply)
    else $error("always-on supply dropped");
  a_cycle_back: assert property ($fell(system_rail) && !ship_mode |-> ##[1:300] system_rail)
    else $error("rail not restored");
  c_ship: cover property ($rose(ship_mode));
  c_second: cover property ($rose(second_press_flag));
  c_cycle: cover property ($fell(system_rail) && !ship_mode);
endmodule
bind pbw_ctrl pbw_ctrl_sva #(.WDOG_CYCLES(WDOG_CYCLES), .CYCLE_OFF_CYCLES(CYCLE_OFF_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) u_pbw_ctrl_sva (.core_clk(core_clk), .reset(reset), .startup_ok(startup_ok),
  .flags_read(flags_read), .mask_first(mask_first), .mask_second(mask_second), .mask_warning(mask_warning),
  .int_oe(int_oe), .first_press_flag(first_press_flag), .second_press_flag(second_press_flag),
  .long_press_warning_flag(long_press_warning_flag), .ship_mode(ship_mode), .system_rail(system_rail),
  .regulator_out(regulator_out), .always_on_supply(always_on_supply));
`default_nettype wire

// ===== test/pbw_partner.sv
// button and host model for the pushbutton wake and reset controller
`timescale 1ns/1ps
`default_nettype none
module pbw_partner (
  // clock
  input wire logic core_clk,
  // to the controller
  output logic button_in_n,
  output logic flags_read
);
  // pull-up: a released button reads high
  initial begin
    button_in_n = 1'b1;
    flags_read = 1'b0;
  end
  // hold the button low for n cycles
  task automatic press(input int n);
    @(negedge core_clk) button_in_n = 1'b0;
    repeat (n) @(negedge core_clk);
    button_in_n = 1'b1;
  endtask
  // host read of the flags, one-cycle pulse
  task automatic read_flags();
    @(negedge core_clk) flags_read = 1'b1;
    @(negedge core_clk) flags_read = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking testbench for the pushbutton wake and reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pbw_pkg::*;
  logic core_clk, reset, button_in_n, input_supply_valid, int_oe, int_out, oe_q;
  logic start_ship_mode, regulator_enable, startup_ok, always_on_supply, system_rail, regulator_out, ship_mode;
  logic [DUR_W-1:0] first_press_timer, second_press_timer, long_press_timer, warning_interval_setting;
  logic [1:0] long_press_action;
  logic reset_requires_input_supply, soft_power_cycle_request, adapter_watchdog_enable, bus_activity, flags_read;
  logic other_int_event, mask_first, mask_second, mask_warning, mask_other;
  logic first_press_flag, second_press_flag, long_press_warning_flag;
  int error_cnt, check_count, npulse, noff, cyc;
  pbw_ctrl #(.WDOG_CYCLES(1000), .CYCLE_OFF_CYCLES(4), .PULSE_CYCLES(8)) u_pbw_ctrl (
    .core_clk(core_clk), .reset(reset), .button_in_n(button_in_n), .input_supply_valid(input_supply_valid),
    .int_oe(int_oe), .int_out(int_out), .start_ship_mode(start_ship_mode), .regulator_enable(regulator_enable),
    .startup_ok(startup_ok), .always_on_supply(always_on_supply), .system_rail(system_rail),
    .regulator_out(regulator_out), .ship_mode(ship_mode), .first_press_timer(first_press_timer),
    .second_press_timer(second_press_timer), .long_press_timer(long_press_timer),
    .warning_interval_setting(warning_interval_setting), .long_press_action(long_press_action),
    .reset_requires_input_supply(reset_requires_input_supply), .soft_power_cycle_request(soft_power_cycle_request),
    .adapter_watchdog_enable(adapter_watchdog_enable), .bus_activity(bus_activity), .flags_read(flags_read),
    .other_int_event(other_int_event), .mask_first(mask_first), .mask_second(mask_second),
    .mask_warning(mask_warning), .mask_other(mask_other), .first_press_flag(first_press_flag),
    .second_press_flag(second_press_flag), .long_press_warning_flag(long_press_warning_flag)
  );
  pbw_partner u_pbw_partner (
    .core_clk(core_clk),
    .button_in_n(button_in_n),
    .flags_read(flags_read)
  );
  // ----------
  // clock, monitors, timeout
  // ----------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    oe_q <= int_oe;
    if (int_oe === 1'b1 && oe_q === 1'b0) npulse++;
    if (system_rail === 1'b0 && ship_mode === 1'b0) noff++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ----------
  // tasks
  // ----------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic go(input int n, input bit rd);
    if (rd) u_pbw_partner.read_flags();
    npulse = 0;
    noff = 0;
    u_pbw_partner.press(n);
    repeat (30) @(negedge core_clk);
    $display("press of %0d cycles done", n);
  endtask
  task automatic wait_plug(input int n);
    input_supply_valid = 1'b0;
    repeat (5) @(negedge core_clk);
    input_supply_valid = 1'b1;
    noff = 0;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    reset = 1'b1;
    {input_supply_valid, start_ship_mode, startup_ok, reset_requires_input_supply, soft_power_cycle_request} = '0;
    {adapter_watchdog_enable, bus_activity, other_int_event, mask_first, mask_second, mask_warning, mask_other} = '0;
    regulator_enable = 1'b1;
    first_press_timer = 32'h0000_0014;
    second_press_timer = 32'h0000_0014;
    long_press_timer = 32'h0000_0064;
    warning_interval_setting = 32'h0000_001e;
    long_press_action = 2'h1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    go(30, 0);
    chk("early_pulse", 0, npulse);
    chk("first_flag", 1, first_press_flag);
    chk("int_out", 0, int_out);
    startup_ok = 1'b1;
    go(50, 1);
    chk("two_pulses", 2, npulse);
    chk("second_flag", 1, second_press_flag);
    go(50, 0);
    chk("no_repeat", 0, npulse);
    u_pbw_partner.read_flags();
    chk("flag_clear", 0, second_press_flag);
    mask_first = 1'b1;
    go(30, 0);
    mask_first = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("masked", 0, npulse);
    go(120, 1);
    chk("warn_flag", 1, long_press_warning_flag);
    chk("three_pulses", 3, npulse);
    chk("nothing", 0, noff);
    long_press_action = 2'h0;
    go(120, 1);
    chk("cycled", 1, noff != 0);
    chk("rail_back", 1, system_rail);
    reset_requires_input_supply = 1'b1;
    go(120, 1);
    chk("gated", 0, noff);
    wait_plug(5);
    go(120, 1);
    chk("gate_ok", 1, noff != 0);
    wait_plug(1200);
    chk("wdog_off", 0, noff);
    adapter_watchdog_enable = 1'b1;
    wait_plug(600);
    bus_activity = 1'b1;
    @(negedge core_clk) bus_activity = 1'b0;
    repeat (700) @(negedge core_clk);
    chk("wdog_fed", 0, noff);
    wait_plug(1100);
    chk("wdog_fire", 1, noff != 0);
    {adapter_watchdog_enable, input_supply_valid, reset_requires_input_supply} = '0;
    long_press_action = 2'h2;
    go(120, 1);
    chk("ship_in", 1, ship_mode);
    go(10, 1);
    chk("ship_stay", 1, ship_mode);
    chk("aon_ship", 0, always_on_supply);
    go(150, 1);
    chk("ship_out", 0, ship_mode);
    chk("reg_up", 1, regulator_out);
    chk("held_quiet", 0, npulse);
    start_ship_mode = 1'b1;
    @(negedge core_clk) start_ship_mode = 1'b0;
    repeat (5) @(negedge core_clk);
    fork
      u_pbw_partner.press(15);
      begin
        repeat (5) @(negedge core_clk);
        chk("aon_wake", 1, always_on_supply);
        chk("wake_dark", 0, system_rail);
        input_supply_valid = 1'b1;
      end
    join
    chk("vin_exit", 0, ship_mode);
    noff = 0;
    soft_power_cycle_request = 1'b1;
    @(negedge core_clk) soft_power_cycle_request = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("soft_cycle", 1, noff != 0);
    npulse = 0;
    other_int_event = 1'b1;
    @(negedge core_clk) other_int_event = 1'b0;
    mask_other = 1'b1;
    repeat (20) @(negedge core_clk);
    other_int_event = 1'b1;
    @(negedge core_clk) other_int_event = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("other_int", 1, npulse);
    close_out();
  end
endmodule
`default_nettype wire
